// file: tbmt_pkg.sv
// tbmt_pkg: constants for the 10 Mbps twisted-pair MII path timing block.
// assumes a single 20 MHz core clock; one bit time at 10 Mbps is two clocks.
package tbmt_pkg;

  // clock and bit time
  localparam int CLK_NS = 50;
  localparam int BT_NS = 100;

  // transmit side figures, in ns
  localparam int TX_CRS_ON_NS = 550;   // 5.5 bit times
  localparam int TX_CRS_OFF_NS = 500;  // 5 bit times
  localparam int TX_LAT_NS = 575;
  localparam int TX_CRS_ON_CYC = (TX_CRS_ON_NS + CLK_NS - 1) / CLK_NS;
  localparam int TX_CRS_OFF_CYC = (TX_CRS_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TX_LAT_CYC = (TX_LAT_NS + CLK_NS - 1) / CLK_NS;

  // receive side figures, in bit times
  localparam int RX_LAT_BT = 64;
  localparam int RX_CRS_BT = 4;        // activity/quiet to carrier and collision
  localparam int RX_LAT_CYC = RX_LAT_BT * BT_NS / CLK_NS;
  localparam int RX_CRS_CYC = RX_CRS_BT * BT_NS / CLK_NS;

  // heartbeat figures, in ns (chosen inside the 650..1600 and 500..1500 windows)
  localparam int SQE_DLY_NS = 1200;
  localparam int SQE_LEN_NS = 950;
  localparam int SQE_DLY_CYC = (SQE_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SQE_LEN_CYC = (SQE_LEN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SQE_CNT_W = 6;

  // jabber figures, in ms (inside 20..150 and 250..750)
  localparam int JAB_MS = 100;
  localparam int UNJAB_MS = 500;
  localparam int JAB_CYC = JAB_MS * 1000000 / CLK_NS;
  localparam int UNJAB_CYC = UNJAB_MS * 1000000 / CLK_NS;
  localparam int JAB_CNT_W = 24;

  // heartbeat sequencer states, gray along idle -> wait -> pulse
  typedef enum logic [1:0] {
    TBMT_SQE_IDLE = 2'b00,
    TBMT_SQE_WAIT = 2'b01,
    TBMT_SQE_PULSE = 2'b11
  } tbmt_sqe_t;

endpackage

// file: tbmt_delay_line.sv
// tbmt_delay_line: fixed-length delay memory, one word per clock.
// assumes the caller wants exactly DEPTH clocks of latency; read data is a register.
`timescale 1ns/1ps
`default_nettype none
module tbmt_delay_line #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];

  // each entry takes its neighbour; the last entry is the registered read port
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = (i == 0) ? din : mem_r[(i == 0) ? 0 : i - 1];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      mem_r <= mem_nxt;
    end
  end

  assign dout = mem_r[DEPTH-1];
endmodule // tbmt_delay_line
`default_nettype wire

// file: tbmt_mii_path.sv
// tbmt_mii_path: 10 Mbps twisted-pair port as seen from its MII, parallel mode.
// assumes MAC and line decoder/encoder run on the same 20 MHz clock; config bits are static levels.
//
// Overview of operation
// - carrier rises 5.5 bit times after transmit enable
// - carrier falls 5 bit times after enable drops
// - line transmit starts 600 ns (575 ns rounded up to 12 clocks) after enable
// - receive data leaves 64 bit times after line
// - data follows carrier by about 60 bit times
// - carrier drops half bit after data valid
// - line activity to carrier, 4 bit times each way
// - collision follows colliding activity by 4 bit times
// - data valid starts at delimiter unless overridden
// - extension bit holds carrier until valid ends
// - heartbeat starts 0.65 to 1.6 us later
// - heartbeat lasts 0.5 to 1.5 us
// - long transmission cut off after 20-150 ms
// - transmit disabled 250-750 ms after cut-off
`timescale 1ns/1ps
`default_nettype none
module tbmt_mii_path #(
  parameter int JAB_CYC = tbmt_pkg::JAB_CYC,
  parameter int UNJAB_CYC = tbmt_pkg::UNJAB_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  // MAC transmit side
  input wire logic tx_en,
  input wire logic [3:0] tx_data,
  input wire logic tx_err,
  // MAC receive side
  output logic [3:0] rx_data,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic col,
  // line encoder side
  output logic line_tx_en,
  output logic [3:0] line_tx_data,
  output logic line_tx_err,
  // line decoder side
  input wire logic line_rx_act,
  input wire logic line_rx_sfd,
  input wire logic [3:0] line_rx_data,
  input wire logic line_rx_err,
  // static configuration, and the jabber status output
  input wire logic cfg_early_dv,
  input wire logic cfg_crs_ext,
  input wire logic cfg_sqe_en,
  output logic jabber
);
  localparam int TXH = tbmt_pkg::TX_CRS_ON_CYC;
  localparam int RXH = tbmt_pkg::RX_CRS_CYC;

  // transmit enable history and transmit carrier
  logic [TXH-1:0] tx_hist_r, tx_hist_nxt;
  logic crs_tx_r, crs_tx_nxt;

  // taps chosen so that the output register lands on the exact cycle
  always_comb begin
    tx_hist_nxt = {tx_hist_r[TXH-2:0], tx_en};
    if (!crs_tx_r) begin
      crs_tx_nxt = tx_hist_r[tbmt_pkg::TX_CRS_ON_CYC-2];
    end else begin
      crs_tx_nxt = tx_hist_r[tbmt_pkg::TX_CRS_OFF_CYC-2];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_hist_r <= '0;
      crs_tx_r <= 1'b0;
    end else begin
      tx_hist_r <= tx_hist_nxt;
      crs_tx_r <= crs_tx_nxt;
    end
  end

  // transmit latency to the line; the output flop adds the last cycle
  logic [5:0] tx_dly;
  tbmt_delay_line #(
    .WIDTH(6),
    .DEPTH(tbmt_pkg::TX_LAT_CYC - 1)
  ) u_tx_dly (
    .clock(clock),
    .nrst(nrst),
    .din({tx_en, tx_err, tx_data}),
    .dout(tx_dly)
  );

  // jabber watchdog: counts transmit time, then holds the line off
  logic jab_r, jab_nxt;
  logic [tbmt_pkg::JAB_CNT_W-1:0] jab_cnt_r, jab_cnt_nxt;

  // the unjab wait is timed from the cut-off, whatever the MAC does meanwhile
  always_comb begin
    jab_nxt = jab_r;
    jab_cnt_nxt = jab_cnt_r;
    if (jab_r) begin
      if (jab_cnt_r == tbmt_pkg::JAB_CNT_W'(UNJAB_CYC - 1)) begin
        jab_nxt = 1'b0;
        jab_cnt_nxt = '0;
      end else begin
        jab_cnt_nxt = jab_cnt_r + 1'b1;
      end
    end else if (!tx_en) begin
      jab_cnt_nxt = '0;
    end else if (jab_cnt_r == tbmt_pkg::JAB_CNT_W'(JAB_CYC - 1)) begin
      jab_nxt = 1'b1;
      jab_cnt_nxt = '0;
    end else begin
      jab_cnt_nxt = jab_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      jab_r <= 1'b0;
      jab_cnt_r <= '0;
    end else begin
      jab_r <= jab_nxt;
      jab_cnt_r <= jab_cnt_nxt;
    end
  end

  // line transmit outputs, blanked while jabbering
  logic line_tx_en_r, line_tx_err_r;
  logic [3:0] line_tx_data_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      line_tx_en_r <= 1'b0;
      line_tx_err_r <= 1'b0;
      line_tx_data_r <= 4'h0;
    end else begin
      line_tx_en_r <= tx_dly[5] & ~jab_nxt;
      line_tx_err_r <= tx_dly[4] & ~jab_nxt;
      line_tx_data_r <= jab_nxt ? 4'h0 : tx_dly[3:0];
    end
  end

  // heartbeat sequencer, started by the falling edge of transmit enable
  tbmt_pkg::tbmt_sqe_t sqe_st_r, sqe_st_nxt;
  logic [tbmt_pkg::SQE_CNT_W-1:0] sqe_cnt_r, sqe_cnt_nxt;
  logic tx_fall;
  assign tx_fall = tx_hist_r[0] & ~tx_en;

  always_comb begin
    sqe_st_nxt = sqe_st_r;
    sqe_cnt_nxt = sqe_cnt_r + 1'b1;
    unique case (sqe_st_r)
      tbmt_pkg::TBMT_SQE_IDLE: begin
        sqe_cnt_nxt = '0;
        if (tx_fall && cfg_sqe_en && !jab_r) begin
          sqe_st_nxt = tbmt_pkg::TBMT_SQE_WAIT;
        end
      end
      tbmt_pkg::TBMT_SQE_WAIT: begin
        if (sqe_cnt_r == tbmt_pkg::SQE_CNT_W'(tbmt_pkg::SQE_DLY_CYC - 2)) begin
          sqe_st_nxt = tbmt_pkg::TBMT_SQE_PULSE;
          sqe_cnt_nxt = '0;
        end
      end
      tbmt_pkg::TBMT_SQE_PULSE: begin
        if (sqe_cnt_r == tbmt_pkg::SQE_CNT_W'(tbmt_pkg::SQE_LEN_CYC - 1)) begin
          sqe_st_nxt = tbmt_pkg::TBMT_SQE_IDLE;
          sqe_cnt_nxt = '0;
        end
      end
      default: begin
        sqe_st_nxt = tbmt_pkg::TBMT_SQE_IDLE;
        sqe_cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sqe_st_r <= tbmt_pkg::TBMT_SQE_IDLE;
      sqe_cnt_r <= '0;
    end else begin
      sqe_st_r <= sqe_st_nxt;
      sqe_cnt_r <= sqe_cnt_nxt;
    end
  end

  // line activity history: carrier and collision follow it by 4 bit times
  logic [RXH-1:0] act_hist_r, act_hist_nxt, coll_hist_r, coll_hist_nxt;
  assign act_hist_nxt = {act_hist_r[RXH-2:0], line_rx_act};
  assign coll_hist_nxt = {coll_hist_r[RXH-2:0], line_rx_act & tx_en};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      act_hist_r <= '0;
      coll_hist_r <= '0;
    end else begin
      act_hist_r <= act_hist_nxt;
      coll_hist_r <= coll_hist_nxt;
    end
  end

  // receive data path: the delimiter mark travels with the nibbles
  logic [6:0] rx_dly;
  tbmt_delay_line #(
    .WIDTH(7),
    .DEPTH(tbmt_pkg::RX_LAT_CYC - 1)
  ) u_rx_dly (
    .clock(clock),
    .nrst(nrst),
    .din({line_rx_act, line_rx_sfd, line_rx_err, line_rx_data}),
    .dout(rx_dly)
  );

  // receive outputs and the combined carrier and collision
  logic rx_dv_r, rx_dv_nxt, rx_er_r, rx_er_nxt, crs_r, crs_nxt, col_r, col_nxt;
  logic pend_r, pend_nxt, dly_act_r, dly_act_nxt;
  logic [3:0] rx_data_r, rx_data_nxt;

  // pend covers the gap between line quiet and the delayed frame ending
  always_comb begin
    if (!rx_dly[6]) begin
      rx_dv_nxt = 1'b0;
    end else if (rx_dv_r || cfg_early_dv || rx_dly[5]) begin
      rx_dv_nxt = 1'b1;
    end else begin
      rx_dv_nxt = 1'b0;
    end
    rx_er_nxt = rx_dv_nxt & rx_dly[4];
    rx_data_nxt = rx_dv_nxt ? rx_dly[3:0] : 4'h0;
    dly_act_nxt = rx_dly[6];
    // cleared when the delayed activity ends, so a fragment with no delimiter holds carrier only until its delayed activity ends
    if (act_hist_r[RXH-2]) begin
      pend_nxt = 1'b1;
    end else if (dly_act_r && !rx_dly[6]) begin
      pend_nxt = 1'b0;
    end else begin
      pend_nxt = pend_r;
    end
    crs_nxt = crs_tx_nxt | act_hist_r[RXH-2] | rx_dv_nxt | rx_dv_r | (cfg_crs_ext & pend_r);
    col_nxt = coll_hist_r[RXH-2] | (sqe_st_nxt == tbmt_pkg::TBMT_SQE_PULSE);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_dv_r <= 1'b0;
      rx_er_r <= 1'b0;
      rx_data_r <= 4'h0;
      crs_r <= 1'b0;
      col_r <= 1'b0;
      pend_r <= 1'b0;
      dly_act_r <= 1'b0;
    end else begin
      rx_dv_r <= rx_dv_nxt;
      rx_er_r <= rx_er_nxt;
      rx_data_r <= rx_data_nxt;
      crs_r <= crs_nxt;
      col_r <= col_nxt;
      pend_r <= pend_nxt;
      dly_act_r <= dly_act_nxt;
    end
  end

  assign rx_data = rx_data_r;
  assign rx_dv = rx_dv_r;
  assign rx_er = rx_er_r;
  assign crs = crs_r;
  assign col = col_r;
  assign line_tx_en = line_tx_en_r;
  assign line_tx_data = line_tx_data_r;
  assign line_tx_err = line_tx_err_r;
  assign jabber = jab_r;
endmodule // tbmt_mii_path
`default_nettype wire

// file: tbmt_mac_model.sv
// tbmt_mac_model: MAC side of the MII, sends one transmit frame on request.
// assumes frame is called at a falling edge and nothing else drives tx_*.
`timescale 1ns/1ps
`default_nettype none
module tbmt_mac_model (
  input wire logic clock,
  output logic tx_en,
  output logic [3:0] tx_data,
  output logic tx_err
);
  initial begin
    tx_en = 1'h0;
    tx_data = 4'h0;
    tx_err = 1'h0;
  end
  // one nibble per clock counting up from 3, error on the sixth; all parked low between frames
  task automatic frame(input int n);
    for (int i = 0; i < n; i++) begin
      tx_en = 1'h1;
      tx_data = 4'(i + 3);
      tx_err = (i == 5);
      @(negedge clock);
    end
    tx_en = 1'h0;
    tx_data = 4'h0;
    tx_err = 1'h0;
  endtask
endmodule // tbmt_mac_model
`default_nettype wire

// file: tbmt_mii_path_sva.sv
// tbmt_mii_path_sva: port-level timing checks for the MII path.
// assumes one clock and config levels that change only while idle.
`timescale 1ns/1ps
`default_nettype none
module tbmt_mii_path_chk #(
  parameter int JAB_CYC = 50,
  parameter int UNJAB_CYC = 200
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic tx_en,
  input wire logic [3:0] tx_data,
  input wire logic [3:0] rx_data,
  input wire logic rx_dv,
  input wire logic crs,
  input wire logic col,
  input wire logic line_tx_en,
  input wire logic [3:0] line_tx_data,
  input wire logic line_rx_act,
  input wire logic line_rx_sfd,
  input wire logic [3:0] line_rx_data,
  input wire logic cfg_early_dv,
  input wire logic cfg_crs_ext,
  input wire logic cfg_sqe_en,
  input wire logic jabber
);
  int run_r, run_nxt, jcnt_r, jcnt_nxt;
  // run lengths of enable and jabber; the jabber bounds allow one clock either way, but the cut-off may come up to three clocks late
  always_comb begin
    run_nxt = tx_en ? run_r + 1 : 0;
    jcnt_nxt = jabber ? jcnt_r + 1 : 0;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_r <= 0;
      jcnt_r <= 0;
    end else begin
      run_r <= run_nxt;
      jcnt_r <= jcnt_nxt;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_crs_on; $rose(tx_en) && !crs && !line_rx_act |-> ##10 !crs ##1 crs; endproperty
  a_crs_on: assert property (p_crs_on) else $error("carrier on");
  property p_crs_off; $fell(tx_en) && !jabber && !line_rx_act && !rx_dv |-> ##10 !crs; endproperty
  a_crs_off: assert property (p_crs_off) else $error("carrier off");
  property p_line; !jabber && !$past(jabber, 12) |->
    line_tx_en == $past(tx_en, 12) && line_tx_data == $past(tx_data, 12); endproperty
  a_line: assert property (p_line) else $error("line copy");
  property p_rxd; rx_dv |-> rx_data == $past(line_rx_data, 128); endproperty
  a_rxd: assert property (p_rxd) else $error("rx data");
  property p_tail; $fell(rx_dv) && !tx_en && !line_rx_act |-> crs ##1 !crs; endproperty
  a_tail: assert property (p_tail) else $error("carrier tail");
  property p_act; $rose(line_rx_act) && !crs |-> ##7 !crs ##1 crs; endproperty
  a_act: assert property (p_act) else $error("rx carrier");
  property p_col; $rose(line_rx_act && tx_en) ##1 (line_rx_act && tx_en)[*7] |-> !col ##1 col; endproperty
  a_col: assert property (p_col) else $error("collision");
  property p_sfd; $rose(line_rx_sfd) && !cfg_early_dv |-> ##127 !rx_dv ##1 rx_dv; endproperty
  a_sfd: assert property (p_sfd) else $error("valid start");
  property p_ext; cfg_crs_ext && $fell(crs) |-> $past(rx_dv, 2); endproperty
  a_ext: assert property (p_ext) else $error("carrier extension");
  property p_hb; $fell(tx_en) && cfg_sqe_en && !jabber && !col |->
    ##23 !col ##1 col[*8] ##11 col ##1 !col; endproperty
  a_hb: assert property (p_hb) else $error("heartbeat");
  property p_jab; run_r == JAB_CYC + 3 |-> jabber; endproperty
  a_jab: assert property (p_jab) else $error("no cut-off");
  property p_jab_early; $rose(jabber) |-> run_r >= JAB_CYC - 1; endproperty
  a_jab_early: assert property (p_jab_early) else $error("early cut-off");
  property p_unjab; $fell(jabber) |-> jcnt_r >= UNJAB_CYC - 1 && jcnt_r <= UNJAB_CYC + 1; endproperty
  a_unjab: assert property (p_unjab) else $error("unjab time");
  c_hb: cover property ($rose(col) && !line_rx_act);
  c_ext: cover property (cfg_crs_ext && $fell(crs));
  c_jab: cover property ($fell(jabber));
endmodule // tbmt_mii_path_chk
bind tbmt_mii_path tbmt_mii_path_chk #(.JAB_CYC(JAB_CYC), .UNJAB_CYC(UNJAB_CYC)) u_chk (.clock, .nrst, .tx_en,
  .tx_data, .rx_data, .rx_dv, .crs, .col, .line_tx_en, .line_tx_data, .line_rx_act, .line_rx_sfd,
  .line_rx_data, .cfg_early_dv, .cfg_crs_ext, .cfg_sqe_en, .jabber);
`default_nettype wire

// file: tb_top.sv
// tb_top: self-checking bench for the 10 Mbps MII path.
// assumes shortened jabber counts; the bench plays the line decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int JAB = 50;
  localparam int UNJAB = 200;
  logic clock = 1'h0, nrst = 1'h0, line_rx_act = 1'h0, line_rx_sfd = 1'h0, line_rx_err = 1'h0;
  logic cfg_early_dv = 1'h0, cfg_crs_ext = 1'h0, cfg_sqe_en = 1'h1;
  logic [3:0] line_rx_data = 4'h0, tx_data, rx_data, line_tx_data;
  logic tx_en, tx_err, rx_dv, rx_er, crs, col, line_tx_en, line_tx_err, jabber;
  int mismatches = 0;
  int comparisons = 0;
  always #25 clock = ~clock;
  tbmt_mac_model u_mac (.clock, .tx_en, .tx_data, .tx_err);
  tbmt_mii_path #(.JAB_CYC(JAB), .UNJAB_CYC(UNJAB)) u_dut (.clock, .nrst, .tx_en, .tx_data, .tx_err, .rx_data,
    .rx_dv, .rx_er, .crs, .col, .line_tx_en, .line_tx_data, .line_tx_err, .line_rx_act, .line_rx_sfd,
    .line_rx_data, .line_rx_err, .cfg_early_dv, .cfg_crs_ext, .cfg_sqe_en, .jabber);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // short frame; step k reads the state after the k-th edge from the start
  task automatic t_tx();
    fork
      u_mac.frame(20);
    join_none
    for (int k = 1; k <= 66; k++) begin
      @(negedge clock);
      check(crs, k inside {[11:29]});
      check({line_tx_err, line_tx_en, line_tx_data}, k inside {[12:31]} ? {k == 17, 1'h1, 4'(k - 9)} : 6'h00);
      check(col, k inside {[44:62]});
    end
  endtask
  // 40-nibble line frame, delimiter at nibbles 8..9, one decode error
  task automatic t_rx(input int c);
    int dv0;
    cfg_early_dv = c[0];
    cfg_crs_ext = c[1];
    dv0 = c[0] ? 128 : 136;
    for (int k = 0; k <= 175; k++) begin
      if (k > 0) begin
        check(rx_dv, k inside {[dv0:167]});
        check(rx_data, k inside {[dv0:167]} ? 4'(k - 128) : 4'h0);
        check(rx_er, k == 148);
        check(crs, k inside {[8:47]} || k inside {[(c[1] ? 8 : dv0):168]});
      end
      line_rx_act = k < 40;
      line_rx_sfd = k inside {[8:9]};
      line_rx_data = 4'(k);
      line_rx_err = k == 20;
      @(negedge clock);
    end
  endtask
  // activity during transmit; heartbeat off, so col shows only the overlap
  task automatic t_col();
    cfg_crs_ext = 1'h0;
    cfg_sqe_en = 1'h0;
    fork
      u_mac.frame(30);
    join_none
    for (int k = 0; k <= 70; k++) begin
      if (k > 0) check(col, k inside {[8:27]});
      line_rx_act = k < 20;
      @(negedge clock);
    end
  endtask
  // endless-looking frame: cut off, line blanked, released after the unjab time
  task automatic t_jab();
    cfg_sqe_en = 1'h1;
    fork
      u_mac.frame(80);
    join_none
    for (int k = 1; k <= 270; k++) begin
      @(negedge clock);
      check(jabber, k inside {[50:249]});
      if (k inside {[50:249]}) check({jabber, line_tx_en, col}, 3'h4);
    end
  endtask
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    nrst = 1'h1;
    @(negedge clock);
    t_tx();
    for (int c = 0; c < 3; c++) t_rx(c);
    t_col();
    t_jab();
    final_report();
  end
  // watchdog: the scenarios need about 1,000 clocks
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
